//--- logic/eth_dma_status_flags.sv
// DMA event status flags, summaries, engine states and register file
`timescale 1ns/1ps
`default_nettype none
module eth_dma_status_flags #(
   parameter int WDG_LIMIT = dma_flags_pkg::WDG_LIMIT_BYTES
) (
   // Clock and reset
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   // AHB-Lite register bus
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic                             hreadyout,
   output logic                             hresp,
   output logic      [31:0]                 hrdata,
   // Engine events
   input  wire dma_flags_pkg::rx_evt_s      rx_evt,
   input  wire dma_flags_pkg::tx_evt_s      tx_evt,
   input  wire dma_flags_pkg::bus_err_s     bus_err,
   // Engine control
   output dma_flags_pkg::eng_e              tx_state,
   output dma_flags_pkg::eng_e              rx_state,
   output logic                             tx_abort,
   output logic                             tx_desc_jabber_set,
   output logic                             rx_desc_overflow_set,
   // Summaries and interrupt
   output logic                             normal_summary_bit,
   output logic                             abnormal_summary_bit,
   output logic [dma_flags_pkg::ETYPE_W-1:0] bus_error_type,
   output logic                             irq
);
   localparam int FW = dma_flags_pkg::FLAG_W;
   localparam int AW = dma_flags_pkg::ADDR_W;
   localparam logic [dma_flags_pkg::LEN_W-1:0] LIMIT = WDG_LIMIT[dma_flags_pkg::LEN_W-1:0];

   // Refuse a limit the length counter cannot hold
   if (WDG_LIMIT < 1 || WDG_LIMIT >= (1 << dma_flags_pkg::LEN_W)) begin : g_bad_limit
      $error("WDG_LIMIT does not fit the frame length width");
   end

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [FW-1:0]       flags;
   logic [FW-1:0]       flag_set;
   logic [FW-1:0]       flag_clr;
   logic [FW-1:0]       dma_irq_enable_mask_r;
   logic                ns_r;
   logic                as_r;
   logic                irq_r;
   logic [dma_flags_pkg::ETYPE_W-1:0] etype_r;
   dma_flags_pkg::eng_e tx_state_r;
   dma_flags_pkg::eng_e rx_state_r;
   dma_flags_pkg::eng_e tx_state_nxt;
   dma_flags_pkg::eng_e rx_state_nxt;
   logic                tx_abort_r;
   logic                tx_jab_desc_r;
   logic                rx_ovf_desc_r;
   logic                wr_en;
   logic [AW-1:0]       wr_addr;
   logic [31:0]         wr_data;
   logic [AW-1:0]       rd_addr;
   logic [31:0]         rd_word;

   // ----------------------------------------
   // Bus front end
   // ----------------------------------------
   ahb_reg_slave #(
      .AW (AW)
   ) u_slave (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .wr_en     (wr_en),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .rd_addr   (rd_addr),
      .rd_word   (rd_word)
   );

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   wire logic wr_status = wr_en & (wr_addr == dma_flags_pkg::OFS_STATUS);
   wire logic wr_clear  = wr_en & (wr_addr == dma_flags_pkg::OFS_CLEAR);
   wire logic wr_enable = wr_en & (wr_addr == dma_flags_pkg::OFS_ENABLE);
   wire logic wr_ctrl   = wr_en & (wr_addr == dma_flags_pkg::OFS_CTRL);
   // Reserved bits are masked out, so stray ones there do nothing
   wire logic [FW-1:0] wdata_flags = wr_data[FW-1:0] & dma_flags_pkg::FLAG_MASK; // [RULE16]
   wire logic tx_resume = wr_ctrl & wr_data[dma_flags_pkg::B_TX_RES];
   wire logic rx_resume = wr_ctrl & wr_data[dma_flags_pkg::B_RX_RES];

   // ----------------------------------------
   // Event decode
   // ----------------------------------------
   wire logic rxb_evt = rx_evt.desc_fetched & ~rx_evt.desc_owned_by_engine;
   wire logic txb_evt = tx_evt.desc_fetched & ~tx_evt.desc_owned_by_engine;
   wire logic txc_evt = tx_evt.frame_end & tx_evt.last_segment_bit
                        & tx_evt.completion_irq_request; // [RULE14]
   wire logic wdg_evt = rx_evt.frame_done & (rx_evt.frame_bytes > LIMIT); // [RULE5]
   wire logic tx_err  = bus_err.resp & ~bus_err.on_rx;
   wire logic rx_err  = bus_err.resp & bus_err.on_rx;

   // Set vector, one term per flag
   always_comb begin
      flag_set = '0;
      flag_set[dma_flags_pkg::B_TXC] = txc_evt;               // [RULE14]
      // Our own stop after jabber counts as a stopped transmitter too
      flag_set[dma_flags_pkg::B_TXS] = tx_evt.in_stop_state   // [RULE13]
                                       | (tx_state_r == dma_flags_pkg::ENG_STOP);
      flag_set[dma_flags_pkg::B_TXB] = txb_evt;               // [RULE12]
      flag_set[dma_flags_pkg::B_JAB] = tx_evt.jabber_expired; // [RULE11]
      flag_set[dma_flags_pkg::B_ROV] = rx_evt.overflow;       // [RULE10]
      flag_set[dma_flags_pkg::B_TUF] = tx_evt.underflow;      // [RULE9]
      flag_set[dma_flags_pkg::B_RXC] = rx_evt.frame_done;     // [RULE8]
      flag_set[dma_flags_pkg::B_RXB] = rxb_evt;               // [RULE7]
      flag_set[dma_flags_pkg::B_RXS] = rx_evt.in_stop_state;  // [RULE6]
      flag_set[dma_flags_pkg::B_WDG] = wdg_evt;               // [RULE5]
      flag_set[dma_flags_pkg::B_ETX] = tx_evt.frame_queued;   // [RULE4]
      flag_set[dma_flags_pkg::B_FTL] = bus_err.resp;          // [RULE2]
      // Completion in the same cycle wins, so early receive stays clear
      flag_set[dma_flags_pkg::B_ERX] = rx_evt.first_buf_filled & ~rx_evt.frame_done; // [RULE1]
   end

   // Clear vector: write one to status or clear register
   always_comb begin
      flag_clr = '0;
      if (wr_status || wr_clear) begin
         flag_clr = wdata_flags; // [RULE15] [RULE19]
      end
      flag_clr[dma_flags_pkg::B_ERX] = flag_clr[dma_flags_pkg::B_ERX]
                                       | rx_evt.frame_done; // [RULE1]
   end

   // ----------------------------------------
   // Sticky flags
   // ----------------------------------------
   sticky_flag_bank #(
      .W (FW)
   ) u_flags (
      .hclk    (hclk),
      .hresetn (hresetn),
      .set     (flag_set),
      .clr     (flag_clr),
      .q_r     (flags)
   );

   // ----------------------------------------
   // Engine states
   // ----------------------------------------
   // Halt outranks stop, stop outranks suspend, resume is weakest
   always_comb begin
      tx_state_nxt = tx_state_r;
      if (tx_err) begin
         tx_state_nxt = dma_flags_pkg::ENG_HALT; // [RULE3]
      end else if (tx_evt.jabber_expired) begin
         tx_state_nxt = dma_flags_pkg::ENG_STOP; // [RULE11]
      end else if (tx_evt.underflow || txb_evt) begin
         tx_state_nxt = dma_flags_pkg::ENG_SUSP; // [RULE9] [RULE12]
      end else if (tx_resume) begin
         tx_state_nxt = dma_flags_pkg::ENG_RUN;
      end
   end

   always_comb begin
      rx_state_nxt = rx_state_r;
      if (rx_err) begin
         rx_state_nxt = dma_flags_pkg::ENG_HALT; // [RULE3]
      end else if (rxb_evt && rx_state_r != dma_flags_pkg::ENG_HALT) begin
         rx_state_nxt = dma_flags_pkg::ENG_SUSP; // [RULE7]
      end else if (rx_resume) begin
         rx_state_nxt = dma_flags_pkg::ENG_RUN;
      end
   end

   // A halted transmitter only leaves halt on resume
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_state_r <= dma_flags_pkg::ENG_RUN;
         rx_state_r <= dma_flags_pkg::ENG_RUN;
      end else begin
         tx_state_r <= (tx_state_r == dma_flags_pkg::ENG_HALT && !tx_resume)
                       ? dma_flags_pkg::ENG_HALT : tx_state_nxt;
         rx_state_r <= rx_state_nxt;
      end
   end

   // Descriptor write-back strobes and abort, one cycle each
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_abort_r    <= 1'b0;
         tx_jab_desc_r <= 1'b0;
         rx_ovf_desc_r <= 1'b0;
      end else begin
         tx_abort_r    <= tx_evt.jabber_expired; // [RULE11]
         tx_jab_desc_r <= tx_evt.jabber_expired; // [RULE11]
         rx_ovf_desc_r <= rx_evt.overflow & rx_evt.part_in_memory; // [RULE10]
      end
   end

   // ----------------------------------------
   // Enable mask, error type, summaries
   // ----------------------------------------
   wire logic [FW-1:0] enabled = flags & dma_irq_enable_mask_r;

   // Summaries lag the flags by one cycle to come from flip-flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dma_irq_enable_mask_r <= dma_flags_pkg::FLAG_RESET;
         etype_r               <= '0;
         ns_r                  <= 1'b0;
         as_r                  <= 1'b0;
         irq_r                 <= 1'b0;
      end else begin
         if (wr_enable) begin
            dma_irq_enable_mask_r <= wdata_flags;
         end
         if (bus_err.resp) begin
            etype_r <= bus_err.etype; // [RULE2]
         end
         ns_r  <= |(enabled & dma_flags_pkg::NORMAL_MASK);   // [RULE17]
         as_r  <= |(enabled & dma_flags_pkg::ABNORMAL_MASK); // [RULE18]
         irq_r <= |enabled;
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   wire logic [31:0] status_word = 32'(flags)
      | (32'(ns_r) << dma_flags_pkg::B_NS)
      | (32'(as_r) << dma_flags_pkg::B_AS)
      | (32'(etype_r) << dma_flags_pkg::B_ETYPE);
   assign rd_word = (rd_addr == dma_flags_pkg::OFS_STATUS) ? status_word
                  : (rd_addr == dma_flags_pkg::OFS_ENABLE) ? 32'(dma_irq_enable_mask_r)
                  : dma_flags_pkg::WORD_ZERO;

   // Outputs
   assign tx_state             = tx_state_r;
   assign rx_state             = rx_state_r;
   assign tx_abort             = tx_abort_r;
   assign tx_desc_jabber_set   = tx_jab_desc_r;
   assign rx_desc_overflow_set = rx_ovf_desc_r;
   assign normal_summary_bit   = ns_r;
   assign abnormal_summary_bit = as_r;
   assign bus_error_type       = etype_r;
   assign irq                  = irq_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_erx_autoclear: assert property ( // [RULE1]
      rx_evt.frame_done |=> !flags[dma_flags_pkg::B_ERX] && flags[dma_flags_pkg::B_RXC])
      else $error("early receive not cleared by receive done");

   a_ftl_type: assert property ( // [RULE2]
      bus_err.resp |=> flags[dma_flags_pkg::B_FTL] && bus_error_type == $past(bus_err.etype))
      else $error("fatal bus error flag or type wrong");

   // Direction comes from the error cycle; the event is gone by then
   a_halt_dir: assert property ( // [RULE3]
      bus_err.resp |=>
         ($past(bus_err.on_rx) ? rx_state : tx_state) == dma_flags_pkg::ENG_HALT)
      else $error("erroring direction not halted");

   a_etx_set: assert property ( // [RULE4]
      $rose(flags[dma_flags_pkg::B_ETX]) |-> $past(tx_evt.frame_queued))
      else $error("early transmit set without queued frame");

   a_wdg_len: assert property ( // [RULE5]
      $rose(flags[dma_flags_pkg::B_WDG]) |->
         $past(rx_evt.frame_done) && $past(rx_evt.frame_bytes) > LIMIT)
      else $error("watchdog flag without long frame");

   a_rxs_level: assert property ( // [RULE6]
      rx_evt.in_stop_state |=> flags[dma_flags_pkg::B_RXS])
      else $error("receive stopped flag not set");

   a_rxb_susp: assert property ( // [RULE7]
      rxb_evt && !bus_err.resp && rx_state != dma_flags_pkg::ENG_HALT |=>
         flags[dma_flags_pkg::B_RXB] && rx_state == dma_flags_pkg::ENG_SUSP)
      else $error("receive buffer unavailable not handled");

   a_tuf_susp: assert property ( // [RULE9]
      tx_evt.underflow && !bus_err.resp && !tx_evt.jabber_expired
         && tx_state != dma_flags_pkg::ENG_HALT |=>
         flags[dma_flags_pkg::B_TUF] && tx_state == dma_flags_pkg::ENG_SUSP)
      else $error("underflow did not suspend transmitter");

   a_rov_desc: assert property ( // [RULE10]
      rx_desc_overflow_set |-> $past(rx_evt.overflow && rx_evt.part_in_memory)
         && flags[dma_flags_pkg::B_ROV])
      else $error("descriptor overflow strobe without cause");

   a_jabber_stop: assert property ( // [RULE11]
      tx_evt.jabber_expired && !bus_err.resp && tx_state != dma_flags_pkg::ENG_HALT
         |=> tx_abort && tx_desc_jabber_set
         && tx_state == dma_flags_pkg::ENG_STOP ##1 !tx_abort)
      else $error("jabber handling wrong");

   a_txc_gate: assert property ( // [RULE14]
      $rose(flags[dma_flags_pkg::B_TXC]) |->
         $past(tx_evt.last_segment_bit && tx_evt.completion_irq_request))
      else $error("transmit done without last segment and request");

   // Summary and irq share one lag, so both rise on the same edge
   a_sum_normal: assert property ( // [RULE17]
      flags[dma_flags_pkg::B_RXC] && dma_irq_enable_mask_r[dma_flags_pkg::B_RXC] |=>
         normal_summary_bit && irq)
      else $error("normal summary not raised");

   a_sum_abn: assert property ( // [RULE18]
      abnormal_summary_bit
         == $past(|(flags & dma_irq_enable_mask_r & dma_flags_pkg::ABNORMAL_MASK)))
      else $error("abnormal summary does not follow enabled flags");

   a_w1c_only: assert property ( // [RULE19]
      $fell(flags[dma_flags_pkg::B_TUF]) |-> $past(wr_status || wr_clear)
         && $past(wr_data[dma_flags_pkg::B_TUF]))
      else $error("flag fell without write one");
endmodule
`default_nettype wire

//--- logic/dma_flags_pkg.sv
// Shared constants and carriers for the DMA event status block
//
// Behaviour
// [RULE1] Early receive set on first buffer, cleared by done
// [RULE2] Bus error response sets fatal flag, keeps type
// [RULE3] Erroring engine direction halts all operations
// [RULE4] Early transmit set once frame fully queued
// [RULE5] Receive watchdog flag on frame over 2048 bytes
// [RULE6] Receive stopped flag while receiver is stopped
// [RULE7] Unowned receive descriptor: flag and suspend receiver
// [RULE8] Receive done flag when frame reception ends
// [RULE9] Transmit underflow: flag and suspend transmitter
// [RULE10] Receive overflow flag, descriptor overflow if partial
// [RULE11] Jabber: flag, abort, stop, descriptor jabber bit
// [RULE12] Unowned transmit descriptor: flag and suspend transmitter
// [RULE13] Transmit stopped flag while transmitter is stopped
// [RULE14] Transmit done only with last segment and request
// [RULE15] Software clears summary sources by writing one
// [RULE16] Software keeps reserved bits 12:11 at reset
// [RULE17] Normal summary ORs enabled normal flags
// [RULE18] Abnormal summary ORs enabled abnormal flags
// [RULE19] Flags stay set until written one; zero ignored
package dma_flags_pkg;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CLEAR  = 8'h04;
   localparam logic [7:0] OFS_ENABLE = 8'h08;
   localparam logic [7:0] OFS_CTRL   = 8'h0C;
   localparam int         ADDR_W     = 8;

   // ----------------------------------------
   // Status field positions
   // ----------------------------------------
   localparam int FLAG_W   = 15;
   localparam int B_TXC    = 0;
   localparam int B_TXS    = 1;
   localparam int B_TXB    = 2;
   localparam int B_JAB    = 3;
   localparam int B_ROV    = 4;
   localparam int B_TUF    = 5;
   localparam int B_RXC    = 6;
   localparam int B_RXB    = 7;
   localparam int B_RXS    = 8;
   localparam int B_WDG    = 9;
   localparam int B_ETX    = 10;
   localparam int B_FTL    = 13;
   localparam int B_ERX    = 14;
   localparam int B_NS     = 15;
   localparam int B_AS     = 16;
   localparam int B_ETYPE  = 23;
   localparam int ETYPE_W  = 3;
   localparam int B_TX_RES = 0;
   localparam int B_RX_RES = 1;

   localparam logic [FLAG_W-1:0] FLAG_MASK     = 15'h67FF;
   localparam logic [FLAG_W-1:0] NORMAL_MASK   = 15'h4045;
   localparam logic [FLAG_W-1:0] ABNORMAL_MASK = 15'h01BA;
   localparam logic [FLAG_W-1:0] FLAG_RESET    = 15'h0000;
   localparam logic [31:0]       WORD_ZERO     = 32'h0000_0000;

   // Watchdog limit and frame length counter width
   localparam int WDG_LIMIT_BYTES = 2048;
   localparam int LEN_W           = 16;

   // Engine states, one-hot
   typedef enum logic [3:0] {
      ENG_RUN  = 4'b0001,
      ENG_SUSP = 4'b0010,
      ENG_STOP = 4'b0100,
      ENG_HALT = 4'b1000
   } eng_e;

   typedef struct packed {
      logic             first_buf_filled;
      logic             frame_done;
      logic [LEN_W-1:0] frame_bytes;
      logic             desc_fetched;
      logic             desc_owned_by_engine;
      logic             overflow;
      logic             part_in_memory;
      logic             in_stop_state;
   } rx_evt_s;

   typedef struct packed {
      logic frame_queued;
      logic underflow;
      logic jabber_expired;
      logic desc_fetched;
      logic desc_owned_by_engine;
      logic in_stop_state;
      logic frame_end;
      logic last_segment_bit;
      logic completion_irq_request;
   } tx_evt_s;

   typedef struct packed {
      logic               resp;
      logic               on_rx;
      logic [ETYPE_W-1:0] etype;
   } bus_err_s;
endpackage

//--- logic/sticky_flag_bank.sv
// Bank of sticky event flags, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_bank #(
   parameter int W = 15
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Per-bit set and clear
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   // Flags
   output logic      [W-1:0] q_r
);
   // ----------------------------------------
   // One flip-flop per flag
   // ----------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_bit
      // Hardware event beats a simultaneous clear
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            q_r[i] <= 1'b0;
         end else if (set[i]) begin
            q_r[i] <= 1'b1;
         end else if (clr[i]) begin
            q_r[i] <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- logic/ahb_reg_slave.sv
// AHB-Lite slave front end: zero-wait, registered read data
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_slave #(
   parameter int AW = 8
) (
   // Clock and reset
   input  wire logic          hclk,
   input  wire logic          hresetn,
   // AHB-Lite
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic               hreadyout,
   output logic               hresp,
   output logic      [31:0]   hrdata,
   // Register side
   output logic               wr_en,
   output logic      [AW-1:0] wr_addr,
   output logic      [31:0]   wr_data,
   output logic      [AW-1:0] rd_addr,
   input  wire logic [31:0]   rd_word
);
   logic          wr_pend_r;
   logic [AW-1:0] wr_addr_r;
   logic [31:0]   hrdata_r;

   // ----------------------------------------
   // Address phase decode
   // ----------------------------------------
   // Only whole-word accesses touch registers; others answer OKAY
   wire logic take = hsel & htrans[1] & hready & (hsize == 3'h2);
   assign rd_addr   = haddr[AW-1:0];
   assign wr_en     = wr_pend_r;
   assign wr_addr   = wr_addr_r;
   assign wr_data   = hwdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   // Capture write target, sample read word at the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
         hrdata_r  <= 32'h0000_0000;
      end else begin
         wr_pend_r <= take & hwrite;
         wr_addr_r <= haddr[AW-1:0];
         if (take && !hwrite) begin
            hrdata_r <= rd_word;
         end
      end
   end
endmodule
`default_nettype wire

//--- verif/test_eth_dma_status_flags.sv
// Self-checking bench for the DMA event status flags block
`timescale 1ns/1ps
`default_nettype none
module test_eth_dma_status_flags;
   // ----------------------------------------
   // Signals and expected flag table
   // ----------------------------------------
   localparam int LIM = 64; // Short watchdog limit keeps frames small
   localparam logic [14:0] EXP_F [15] = '{15'h0001, 15'h0020, 15'h000A, 15'h0004,
      15'h0400, 15'h0002, 15'h0040, 15'h0240, 15'h0080, 15'h0010, 15'h0100, 15'h4000,
      15'h2000, 15'h0000, 15'h0000};
   logic                    hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, nsum, asum;
   logic                    dir, tx_abort, jab_set, ovf_set;
   logic [1:0]              htrans;
   logic [2:0]              hsize, bus_error_type, ety, pul;
   logic [7:0]              stv;
   logic [14:0]             f;
   logic [31:0]             haddr, hwdata, hrdata, en, ex;
   dma_flags_pkg::rx_evt_s  rx_evt;
   dma_flags_pkg::tx_evt_s  tx_evt;
   dma_flags_pkg::bus_err_s bus_err;
   dma_flags_pkg::eng_e     tx_state, rx_state;
   int                      n_mismatch, n_checks, cyc, k;

   // Single slave, so its ready is the bus ready
   eth_dma_status_flags #(.WDG_LIMIT(LIM)) eth_dma_status_flags_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_evt(rx_evt),
      .tx_evt(tx_evt), .bus_err(bus_err), .tx_state(tx_state), .rx_state(rx_state),
      .tx_abort(tx_abort), .tx_desc_jabber_set(jab_set), .rx_desc_overflow_set(ovf_set),
      .normal_summary_bit(nsum), .abnormal_summary_bit(asum),
      .bus_error_type(bus_error_type), .irq(irq));

   // ----------------------------------------
   // Bus, event and check tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Holds each phase until ready is seen high; no latency assumed
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'h1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'h1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, q);
      chk(q & m, e);
   endtask

   // One-cycle event; outputs captured in the cycle after it is taken
   task automatic fire(input int n);
      @(posedge hclk);
      case (n)
         0: tx_evt <= 9'h007;
         1: tx_evt <= 9'h080;
         2: tx_evt <= 9'h040;
         3: tx_evt <= 9'h020;
         4: tx_evt <= 9'h100;
         5: tx_evt <= 9'h008;
         6: rx_evt <= {2'h1, 16'(LIM), 5'h00};
         7: rx_evt <= {2'h1, 16'(LIM + 1), 5'h00};
         8: rx_evt <= 23'h000010;
         9: rx_evt <= 23'h000006;
         10: rx_evt <= 23'h000001;
         11: rx_evt <= 23'h400000;
         12: bus_err <= {1'h1, dir, ety};
         13: tx_evt <= 9'h006;
         default: rx_evt <= 23'h000018;
      endcase
      @(posedge hclk);
      rx_evt  <= '0;
      tx_evt  <= '0;
      bus_err <= '0;
      #1;
      pul = {tx_abort, jab_set, ovf_set};
      stv = {tx_state, rx_state};
   endtask

   // Engine states after event n, transmitter in the upper nibble
   function automatic logic [7:0] exp_st(input int n);
      logic [3:0] t;
      logic [3:0] s;
      t = (n == 1 || n == 3) ? 4'h2 : (n == 2) ? 4'h4 : 4'h1;
      s = (n == 8) ? 4'h2 : 4'h1;
      if (n == 12 && dir) s = 4'h8;
      if (n == 12 && !dir) t = 4'h8;
      return {t, s};
   endfunction

   task automatic final_report;
      if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ----------------------------------------
   // Clock, hang guard and main sequence
   // ----------------------------------------
   initial begin
      hclk = 1'h0;
      forever #2.5 hclk = ~hclk;
   end

   // Run needs about 1500 cycles, so this only trips on a hang
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end

   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, dir, ety} = '0;
      hsize = 3'h2;
      {rx_evt, tx_evt, bus_err} = '0;
      {n_mismatch, n_checks, cyc} = '0;
      en = $urandom(68171);
      repeat (6) @(posedge hclk);
      hresetn <= 1'h1;
      rd(8'h00, 32'hFFFF_FFFF, 32'h0);
      rd(8'h08, 32'hFFFF_FFFF, 32'h0);
      chk({23'h0, tx_state, rx_state, hresp}, {23'h0, 8'h11, 1'h0});
      rd(8'h10, 32'hFFFF_FFFF, 32'h0);
      rd(8'h04, 32'hFFFF_FFFF, 32'h0);
      // Every event three times, random enable mask, direction and error type
      for (int n = 0; n < 45; n++) begin
         k = n % 15;
         en = $urandom & ((k == 2) ? 32'h7FFD : 32'h7FFF);
         {dir, ety} = 4'($urandom);
         wr(8'h08, en);
         wr(8'h14, 32'h7FFF);
         rd(8'h08, 32'hFFFF_FFFF, en & 32'h67FF);
         fire(k);
         chk({29'h0, pul}, (k == 2) ? 32'h6 : (k == 9) ? 32'h1 : 32'h0);
         chk({24'h0, stv}, {24'h0, exp_st(k)});
         f  = EXP_F[k];
         ex = {15'h0, |(f & en[14:0] & dma_flags_pkg::ABNORMAL_MASK),
               |(f & en[14:0] & dma_flags_pkg::NORMAL_MASK), f};
         rd(8'h00, 32'h0001_FFFF, ex);
         #1;
         chk({29'h0, irq, nsum, asum},
             {29'h0, |(f & en[14:0]), ex[15], ex[16]});
         if (k == 12) chk({29'h0, bus_error_type}, {29'h0, ety});
         wr(8'h04, 32'h0);
         wr(8'h00, 32'h0);
         rd(8'h00, 32'h7FFF, {17'h0, f});
         wr(8'h0C, 32'h3);
         wr(n[0] ? 8'h04 : 8'h00, {17'h0, f});
         rd(8'h00, 32'h0001_FFFF, 32'h0);
         #1;
         chk({31'h0, irq}, 32'h0);
      end
      // Early receive is dropped when reception completes
      fire(11);
      fire(6);
      rd(8'h00, 32'h7FFF, 32'h0040);
      final_report();
   end
endmodule
`default_nettype wire
